// ### include/brsp_cfg.svh
// timing counts and strap encodings for the boot rom serial port
`ifndef BRSP_CFG_SVH
`define BRSP_CFG_SVH
`define BRSP_CLK_MHZ       125
`define BRSP_RATE_SLOW_MHZ 30
`define BRSP_RATE_FAST_MHZ 60
// half serial period in clocks, rounded up so the rate never exceeds the limit
`define BRSP_HALF_SLOW ((`BRSP_CLK_MHZ + 2*`BRSP_RATE_SLOW_MHZ - 1) / (2*`BRSP_RATE_SLOW_MHZ))
`define BRSP_HALF_FAST ((`BRSP_CLK_MHZ + 2*`BRSP_RATE_FAST_MHZ - 1) / (2*`BRSP_RATE_FAST_MHZ))
`define BRSP_STRAP_SLOW    1'h0
`define BRSP_STRAP_FAST    1'h1
`define BRSP_BYTE_BITS     8
`define BRSP_LAST_BIT      3'h7
`endif

// ### include/brsp_pkg.sv
// types shared by the boot rom serial port pin logic
package brsp_pkg;
  typedef enum logic [1:0] {
    BRSP_MODE_ROM,
    BRSP_MODE_GPIO,
    BRSP_MODE_TWI
  } brsp_mode_t;

  typedef struct packed {
    logic out;
    logic oe;
  } brsp_pin_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } brsp_byte_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } brsp_byte_rsp_t;
endpackage

// ### design/brsp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module brsp_sync #(
  parameter int W = 1
) (
  input  wire logic         i_ref_clk,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // no reset: a reset here would only fake a pin level for two cycles
  always_ff @(posedge i_ref_clk) begin
    meta_ff <= i_async;
    sync_ff <= meta_ff;
  end

  assign o_sync = sync_ff;
endmodule

// ### design/brsp_top.sv
// serial boot rom port pin control with strap latch and shared pin modes
`timescale 1ns/1ps
`include "brsp_cfg.svh"

// What this block does
// RL1: chip select is driven low to select the memory and held high in power-down while the port is enabled.
// RL2: the serial clock goes out to the memory and is held low for as long as reset is asserted.
// RL3: during reset the data-out/strap pin is left undriven with its weak pull-down on.
// RL4: on reset release the strap level is latched, the pull-down is dropped and the pin becomes data out.
// RL5: the port runs at the slow rate for strap 0 and the fast rate for strap 1.
// RL6: the board fits no resistor for the slow rate and a pull-up for the fast rate.
// RL7: with strap 1 the data-out pin floats during suspend.
// RL8: with strap 0 the data-out pin is driven low during suspend.
// RL9: in normal use the data-out pin shifts command and address bits to the memory.
// RL10: read data comes in on the data-in pin, which always has a weak pull-down.
// RL11: firmware may turn the clock and data-out pins into inputs, edge inputs or outputs.
// RL12: with a two-wire eeprom the clock pin serves as that eeprom's clock.
// RL13: with a two-wire eeprom the data-out pin serves as that eeprom's data line.
// RL14: chip select stays low through a transaction, the clock toggles only then, and data follows it.
module brsp_top
  import brsp_pkg::*;
(
  input  wire logic           i_ref_clk,
  input  wire logic           i_srst,
  input  wire logic           i_port_enable,
  input  wire logic           i_power_down,
  input  wire logic           i_suspend,
  input  brsp_mode_t          i_pin_mode,
  input  brsp_byte_req_t      i_byte_req,
  output logic                o_byte_ready,
  output brsp_byte_rsp_t      o_byte_rsp,
  input  wire logic [1:0]     i_gpio_out,
  input  wire logic [1:0]     i_gpio_oe,
  input  wire logic [1:0]     i_gpio_edge_rise,
  output logic      [1:0]     o_gpio_in,
  output logic      [1:0]     o_gpio_edge,
  input  wire logic           i_twi_scl_low,
  input  wire logic           i_twi_sda_low,
  output logic                o_twi_scl_in,
  output logic                o_twi_sda_in,
  output logic                o_strap_valid,
  output logic                o_strap_fast,
  output logic                o_busy,
  input  wire logic           i_shared_io_clock_pin,
  output brsp_pin_t           o_shared_io_clock_pin,
  input  wire logic           i_shared_io_data_pin,
  output brsp_pin_t           o_shared_io_data_pin,
  output logic                o_rom_rate_strap_pd_en,
  input  wire logic           i_rom_serial_in,
  output logic                o_rom_serial_in_pd_en,
  output brsp_pin_t           o_rom_sel_n_pin
);
  typedef enum logic {ST_IDLE, ST_SHIFT} brsp_state_t;

  logic [2:0] pins_sync;
  logic       clk_pin_s;
  logic       dat_pin_s;
  logic       di_s;

  brsp_sync #(.W(3)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_async   ({i_shared_io_clock_pin, i_shared_io_data_pin, i_rom_serial_in}),
    .o_sync    (pins_sync)
  );
  assign clk_pin_s = pins_sync[2];
  assign dat_pin_s = pins_sync[1];
  assign di_s      = pins_sync[0];

  // strap capture: the synchronised pin is taken on the first edge after release
  logic rst_d_ff;
  logic strap_valid_ff;
  logic strap_fast_ff;
  logic nxt_strap_valid;
  logic nxt_strap_fast;

  always_comb begin
    nxt_strap_valid = strap_valid_ff;
    nxt_strap_fast  = strap_fast_ff;
    if (i_srst) begin
      nxt_strap_valid = 1'b0;
      nxt_strap_fast  = `BRSP_STRAP_SLOW;
    end else if (rst_d_ff) begin
      nxt_strap_valid = 1'b1; // RL4
      nxt_strap_fast  = dat_pin_s; // RL4
    end
  end

  always_ff @(posedge i_ref_clk) begin
    rst_d_ff       <= i_srst;
    strap_valid_ff <= nxt_strap_valid;
    strap_fast_ff  <= nxt_strap_fast;
  end

  // serial engine
  brsp_state_t state_ff;
  brsp_state_t nxt_state;
  logic [1:0]  half_cnt_ff;
  logic [1:0]  nxt_half_cnt;
  logic [2:0]  bit_cnt_ff;
  logic [2:0]  nxt_bit_cnt;
  logic [7:0]  tx_sh_ff;
  logic [7:0]  nxt_tx_sh;
  logic [7:0]  rx_sh_ff;
  logic [7:0]  nxt_rx_sh;
  logic        last_ff;
  logic        nxt_last;
  logic        sclk_ff;
  logic        nxt_sclk;
  logic        sel_ff;
  logic        nxt_sel;
  logic        rsp_valid_ff;
  logic        nxt_rsp_valid;
  logic [7:0]  rsp_data_ff;
  logic [7:0]  nxt_rsp_data;
  logic [1:0]  half_top;
  logic        port_live;

  always_comb begin
    if (strap_fast_ff == `BRSP_STRAP_FAST) begin
      half_top = 2'(`BRSP_HALF_FAST - 1); // RL5
    end else begin
      half_top = 2'(`BRSP_HALF_SLOW - 1); // RL5
    end
  end

  assign port_live    = i_port_enable && strap_valid_ff && !i_power_down && !i_suspend
                        && (i_pin_mode == BRSP_MODE_ROM);
  assign o_byte_ready = port_live && (state_ff == ST_IDLE);

  always_comb begin
    nxt_state     = state_ff;
    nxt_half_cnt  = half_cnt_ff;
    nxt_bit_cnt   = bit_cnt_ff;
    nxt_tx_sh     = tx_sh_ff;
    nxt_rx_sh     = rx_sh_ff;
    nxt_last      = last_ff;
    nxt_sclk      = sclk_ff;
    nxt_sel       = sel_ff;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_data  = rsp_data_ff;
    if (!port_live) begin
      // leaving the port mid-byte abandons the transaction cleanly
      nxt_state    = ST_IDLE;
      nxt_sclk     = 1'b0;
      nxt_sel      = 1'b0; // RL1
      nxt_half_cnt = 2'h0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          nxt_sclk = 1'b0; // RL14
          if (i_byte_req.valid) begin
            nxt_state    = ST_SHIFT;
            nxt_sel      = 1'b1; // RL14
            nxt_tx_sh    = i_byte_req.data; // RL9
            nxt_last     = i_byte_req.last;
            nxt_bit_cnt  = 3'h0;
            nxt_half_cnt = 2'h0;
          end
        end
        ST_SHIFT: begin
          nxt_half_cnt = half_cnt_ff + 2'h1;
          if (half_cnt_ff == half_top) begin
            nxt_half_cnt = 2'h0;
            nxt_sclk     = !sclk_ff; // RL14
            if (sclk_ff) begin
              // sampled at the falling edge: the two-flop delay then looks back
              // to about the rising edge, where the memory's data is settled
              nxt_rx_sh = {rx_sh_ff[6:0], di_s}; // RL10
              if (bit_cnt_ff == `BRSP_LAST_BIT) begin
                nxt_state     = ST_IDLE;
                nxt_rsp_valid = 1'b1;
                nxt_rsp_data  = {rx_sh_ff[6:0], di_s};
                nxt_sel       = !last_ff; // RL14
              end else begin
                nxt_bit_cnt = bit_cnt_ff + 3'h1;
                nxt_tx_sh   = {tx_sh_ff[6:0], 1'b0}; // RL9
              end
            end
          end
        end
      endcase
    end
    if (i_srst) begin
      nxt_state     = ST_IDLE;
      nxt_half_cnt  = 2'h0;
      nxt_bit_cnt   = 3'h0;
      nxt_tx_sh     = 8'h00;
      nxt_rx_sh     = 8'h00;
      nxt_last      = 1'b0;
      nxt_sclk      = 1'b0; // RL2
      nxt_sel       = 1'b0;
      nxt_rsp_valid = 1'b0;
      nxt_rsp_data  = 8'h00;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    state_ff     <= nxt_state;
    half_cnt_ff  <= nxt_half_cnt;
    bit_cnt_ff   <= nxt_bit_cnt;
    tx_sh_ff     <= nxt_tx_sh;
    rx_sh_ff     <= nxt_rx_sh;
    last_ff      <= nxt_last;
    sclk_ff      <= nxt_sclk;
    sel_ff       <= nxt_sel;
    rsp_valid_ff <= nxt_rsp_valid;
    rsp_data_ff  <= nxt_rsp_data;
  end

  assign o_byte_rsp    = '{valid: rsp_valid_ff, data: rsp_data_ff};
  assign o_busy        = sel_ff;
  assign o_strap_valid = strap_valid_ff;
  assign o_strap_fast  = strap_fast_ff;

  // pin drive: computed here, registered so pads see clean levels
  brsp_pin_t clk_pin_ff;
  brsp_pin_t dat_pin_ff;
  brsp_pin_t sel_pin_ff;
  brsp_pin_t nxt_clk_pin;
  brsp_pin_t nxt_dat_pin;
  brsp_pin_t nxt_sel_pin;
  logic      dat_pd_ff;
  logic      nxt_dat_pd;

  always_comb begin
    nxt_clk_pin = '{out: sclk_ff, oe: 1'b1};
    nxt_dat_pin = '{out: tx_sh_ff[7], oe: 1'b1}; // RL9
    nxt_dat_pd  = 1'b0; // RL4
    nxt_sel_pin = '{out: !sel_ff, oe: i_port_enable}; // RL1
    if (i_power_down && i_port_enable) begin
      nxt_sel_pin = '{out: 1'b1, oe: 1'b1}; // RL1
    end
    unique case (i_pin_mode)
      BRSP_MODE_ROM: begin
      end
      BRSP_MODE_GPIO: begin
        nxt_clk_pin = '{out: i_gpio_out[1], oe: i_gpio_oe[1]}; // RL11
        nxt_dat_pin = '{out: i_gpio_out[0], oe: i_gpio_oe[0]}; // RL11
      end
      BRSP_MODE_TWI: begin
        // open drain: only ever pulls low
        nxt_clk_pin = '{out: 1'b0, oe: i_twi_scl_low}; // RL12
        nxt_dat_pin = '{out: 1'b0, oe: i_twi_sda_low}; // RL13
      end
      default: begin
        nxt_clk_pin = '{out: 1'b0, oe: 1'b1};
        nxt_dat_pin = '{out: 1'b0, oe: 1'b0};
      end
    endcase
    if (i_suspend) begin
      if (strap_fast_ff == `BRSP_STRAP_FAST) begin
        nxt_dat_pin = '{out: 1'b0, oe: 1'b0}; // RL7
      end else begin
        nxt_dat_pin = '{out: 1'b0, oe: 1'b1}; // RL8
      end
    end
    // until the strap is taken the pin stays a pulled-down input
    if (i_srst || !strap_valid_ff) begin
      nxt_dat_pin = '{out: 1'b0, oe: 1'b0}; // RL3
      nxt_dat_pd  = 1'b1; // RL3
    end
    if (i_srst) begin
      nxt_clk_pin = '{out: 1'b0, oe: 1'b1}; // RL2
      nxt_sel_pin = '{out: 1'b1, oe: 1'b1};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    clk_pin_ff <= nxt_clk_pin;
    dat_pin_ff <= nxt_dat_pin;
    sel_pin_ff <= nxt_sel_pin;
    dat_pd_ff  <= nxt_dat_pd;
  end

  assign o_shared_io_clock_pin  = clk_pin_ff;
  assign o_shared_io_data_pin   = dat_pin_ff;
  assign o_rom_sel_n_pin        = sel_pin_ff;
  assign o_rom_rate_strap_pd_en = dat_pd_ff;
  assign o_rom_serial_in_pd_en  = 1'b1; // RL10

  // shared pins read back as inputs and edge events
  logic [1:0] gpio_d_ff;
  logic [1:0] nxt_gpio_d;
  logic [1:0] edge_ff;
  logic [1:0] nxt_edge;

  always_comb begin
    nxt_gpio_d = {clk_pin_s, dat_pin_s};
    nxt_edge   = 2'h0;
    for (int k = 0; k < 2; k++) begin
      if (i_pin_mode == BRSP_MODE_GPIO && !i_srst) begin
        nxt_edge[k] = i_gpio_edge_rise[k] ? (nxt_gpio_d[k] && !gpio_d_ff[k])
                                          : (!nxt_gpio_d[k] && gpio_d_ff[k]); // RL11
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    gpio_d_ff <= nxt_gpio_d;
    edge_ff   <= nxt_edge;
  end

  assign o_gpio_in    = gpio_d_ff;
  assign o_gpio_edge  = edge_ff;
  assign o_twi_scl_in = gpio_d_ff[1]; // RL12
  assign o_twi_sda_in = gpio_d_ff[0]; // RL13
endmodule

// ### verif/brsp_monitor.sv
// assertion checker for the boot rom serial port pins
`timescale 1ns/1ps
module brsp_monitor
  import brsp_pkg::*;
(
  input wire logic      i_ref_clk,
  input wire logic      i_srst,
  input wire logic      i_port_enable,
  input wire logic      i_power_down,
  input wire logic      i_suspend,
  input brsp_mode_t     i_pin_mode,
  input brsp_byte_req_t i_byte_req,
  input wire logic      o_byte_ready,
  input brsp_byte_rsp_t o_byte_rsp,
  input wire logic      o_strap_valid,
  input wire logic      o_strap_fast,
  input brsp_pin_t      o_shared_io_clock_pin,
  input brsp_pin_t      o_shared_io_data_pin,
  input wire logic      o_rom_rate_strap_pd_en,
  input brsp_pin_t      o_rom_sel_n_pin
);
  default clocking cb @(posedge i_ref_clk); endclocking
  // reset is the cause here, so these three cannot be disabled by it
  AST_RST_CLK: assert property (i_srst |=> o_shared_io_clock_pin == 2'h1)
    else $error("clock pin not low in reset");
  AST_RST_DATA: assert property (i_srst |=> !o_shared_io_data_pin.oe && o_rom_rate_strap_pd_en)
    else $error("strap pin not released in reset");
  AST_SEL_HIGH: assert property ((i_srst || (i_power_down && i_port_enable))
    |=> o_rom_sel_n_pin == 2'h3)
    else $error("select not high");
  AST_STRAP_LATCH: assert property (disable iff (i_srst)
    $fell(i_srst) |=> o_strap_valid ##1 !o_rom_rate_strap_pd_en)
    else $error("strap not latched on release");
  AST_SUSP_FAST: assert property (disable iff (i_srst)
    o_strap_valid && o_strap_fast && i_suspend |=> !o_shared_io_data_pin.oe)
    else $error("data pin driven in suspend");
  AST_SUSP_SLOW: assert property (disable iff (i_srst)
    o_strap_valid && !o_strap_fast && i_suspend |=> o_shared_io_data_pin == 2'h1)
    else $error("data pin not low in suspend");
  AST_SCLK_SEL: assert property (disable iff (i_srst) $rose(o_shared_io_clock_pin.out)
    && $past(i_pin_mode) == BRSP_MODE_ROM && $past(i_pin_mode, 2) == BRSP_MODE_ROM
    |-> !o_rom_sel_n_pin.out)
    else $error("clock toggles without select");
  AST_LAT_FAST: assert property (disable iff (i_srst)
    i_byte_req.valid && o_byte_ready && o_strap_fast |-> ##33 o_byte_rsp.valid)
    else $error("fast byte latency wrong");
endmodule

bind brsp_top brsp_monitor u_mon (
  .i_ref_clk              (i_ref_clk),
  .i_srst                 (i_srst),
  .i_port_enable          (i_port_enable),
  .i_power_down           (i_power_down),
  .i_suspend              (i_suspend),
  .i_pin_mode             (i_pin_mode),
  .i_byte_req             (i_byte_req),
  .o_byte_ready           (o_byte_ready),
  .o_byte_rsp             (o_byte_rsp),
  .o_strap_valid          (o_strap_valid),
  .o_strap_fast           (o_strap_fast),
  .o_shared_io_clock_pin  (o_shared_io_clock_pin),
  .o_shared_io_data_pin   (o_shared_io_data_pin),
  .o_rom_rate_strap_pd_en (o_rom_rate_strap_pd_en),
  .o_rom_sel_n_pin        (o_rom_sel_n_pin)
);

// ### verif/brsp_rom_model.sv
// behavioural serial rom answering on the data-in pin
`timescale 1ns/1ps
module brsp_rom_model (
  input  wire logic       i_sel_n,
  input  wire logic       i_sclk,
  input  wire logic       i_mosi,
  input  wire logic [7:0] i_reply,
  output logic            o_miso,
  output logic      [7:0] o_got
);
  logic [7:0] sh = 8'h00;
  int         cnt = 0;
  // a released line falls to the weak pull-down on data-in
  assign o_miso = i_sel_n ? 1'b0 : sh[7];
  always @(negedge i_sel_n) begin
    sh = i_reply;
    cnt = 0;
  end
  // next bit moves on the falling clock so it is steady across the rising one
  always @(negedge i_sclk) begin
    if (!i_sel_n) begin
      cnt = cnt + 1;
      sh = (cnt == 8) ? i_reply : {sh[6:0], 1'b0};
      if (cnt == 8) cnt = 0;
    end
  end
  always @(posedge i_sclk) if (!i_sel_n) o_got = {o_got[6:0], i_mosi};
endmodule

// ### verif/brsp_top_test.sv
// self-checking bench for the boot rom serial port pins
`timescale 1ns/1ps
`include "brsp_cfg.svh"
module brsp_top_test;
  import brsp_pkg::*;
  logic           clk = 0, srst = 1, en = 1, pd = 0, susp = 0, scl_lo = 0, sda_lo = 0;
  logic           ext_clk = 1, ext_dat = 0, rdy, dpd, dipd, sv, sf, busy, scl_in, sda_in, miso;
  logic [1:0]     g_out = 0, g_oe = 0, g_rise = 2'h3, g_in, g_edge, e2;
  logic [7:0]     reply = 0, got;
  brsp_mode_t     mode = BRSP_MODE_ROM;
  brsp_byte_req_t req = '0;
  brsp_byte_rsp_t rsp;
  brsp_pin_t      cpin, dpin, sel;
  int             seed = 4, n_fail = 0, tests_run = 0;
  // an undriven strap pin settles to the board resistor: pull-up picks the fast rate
  wire clk_lvl = cpin.oe ? cpin.out : ext_clk;
  wire dat_lvl = dpin.oe ? dpin.out : ext_dat;
  wire sel_lvl = sel.oe ? sel.out : 1'b1;
  always #4 clk = ~clk;
  brsp_top dut (.i_ref_clk(clk), .i_srst(srst), .i_port_enable(en), .i_power_down(pd),
    .i_suspend(susp), .i_pin_mode(mode), .i_byte_req(req), .o_byte_ready(rdy),
    .o_byte_rsp(rsp), .i_gpio_out(g_out), .i_gpio_oe(g_oe), .i_gpio_edge_rise(g_rise),
    .o_gpio_in(g_in), .o_gpio_edge(g_edge), .i_twi_scl_low(scl_lo), .i_twi_sda_low(sda_lo),
    .o_twi_scl_in(scl_in), .o_twi_sda_in(sda_in), .o_strap_valid(sv), .o_strap_fast(sf),
    .o_busy(busy), .i_shared_io_clock_pin(clk_lvl), .o_shared_io_clock_pin(cpin),
    .i_shared_io_data_pin(dat_lvl), .o_shared_io_data_pin(dpin),
    .o_rom_rate_strap_pd_en(dpd), .i_rom_serial_in(miso), .o_rom_serial_in_pd_en(dipd),
    .o_rom_sel_n_pin(sel));
  brsp_rom_model rom (.i_sel_n(sel_lvl), .i_sclk(clk_lvl), .i_mosi(dat_lvl),
    .i_reply(reply), .o_miso(miso), .o_got(got));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one half period per serial clock edge, two edges per bit, counted from the take edge
  function automatic int lat(input logic fast);
    return 2 * `BRSP_BYTE_BITS * (fast ? `BRSP_HALF_FAST : `BRSP_HALF_SLOW);
  endfunction
  task automatic xfer(input logic [7:0] d, input logic lst, input logic fast);
    logic [7:0] e;
    int         n;
    e = reply;
    n = 0;
    req = '{1'b1, d, lst};
    while (rdy !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    tick(1);
    req.valid = 1'b0;
    n = 0;
    while (rsp.valid !== 1'b1 && n < 300) begin
      tick(1);
      n++;
      // the rom has loaded this byte's reply once select is low
      if (n == 3) begin
        reply = 8'($random(seed));
        chk({sel_lvl, busy}, 8'h01);
      end
    end
    chk(8'(n), 8'(lat(fast)));
    chk(rsp.data, e);
    chk(got, d);
  endtask
  initial begin
    for (int s = 0; s < 2; s++) begin
      srst = 1'b1;
      ext_dat = s[0];
      tick(16);
      chk(cpin, 8'h01);
      chk({dpin.oe, dpd}, 8'h01);
      chk(sel, 8'h03);
      srst = 1'b0;
      tick(3);
      chk({sv, sf}, {1'b1, s[0]});
      chk({dpd, dipd}, 8'h01);
      for (int k = 0; k < 6; k++) begin
        xfer(k == 4 ? 8'h00 : k == 5 ? 8'hff : 8'($random(seed)), k == 3 || k == 5, s[0]);
      end
      susp = 1'b1;
      tick(2);
      chk({dpin.oe, dpin.oe & dpin.out}, s[0] ? 8'h00 : 8'h02);
      susp = 1'b0;
      pd = 1'b1;
      tick(2);
      chk(sel, 8'h03);
      pd = 1'b0;
    end
    mode = BRSP_MODE_GPIO;
    g_oe = 2'h3;
    g_out = 2'($random(seed));
    tick(2);
    chk({cpin.out, dpin.out, cpin.oe, dpin.oe}, {g_out, 2'h3});
    g_oe = 2'h0;
    ext_clk = 1'b0;
    ext_dat = 1'($random(seed));
    tick(6);
    chk(g_in, {ext_clk, ext_dat});
    ext_clk = 1'b1;
    e2 = 2'h0;
    repeat (6) begin
      tick(1);
      e2 |= g_edge;
    end
    chk(e2, 8'h02);
    mode = BRSP_MODE_TWI;
    ext_dat = 1'b1;
    scl_lo = 1'b1;
    sda_lo = 1'b1;
    tick(5);
    chk({cpin, dpin, scl_in, sda_in}, 8'h14);
    scl_lo = 1'b0;
    sda_lo = 1'b0;
    tick(5);
    chk({cpin.oe, dpin.oe, scl_in, sda_in}, 8'h03);
    print_verdict;
  end
  initial begin
    #200000;
    n_fail++;
    print_verdict;
  end
endmodule
